// [src/afe_host_pin_interface.sv]
`timescale 1ns/1ns
// What this block does
// - Output disable high tri-states every bus bit
// - Shared pin: serial enable high, parallel strobe low
// - Reset rising edge latches strobe level: mode
// - Parallel: data/address select high data, low address
// - Parallel: read select drives upper byte, else input
// - Serial: clock pin shifts, data pin feeds bits
// - Outside line mode: clamp select high clamps that pixel
// - Line mode: autocycle steps red, green, blue
// - Full-width format presents whole 14-bit result
// - Multiplexed formats give 8, 7, 4-bit pieces
// - Parallel write byte taken on strobe low
// - Parallel read byte driven while strobe low
// - Serial read-back on top bit after enable
// - Reset low returns registers to defaults
module afe_host_pin_interface #(
  parameter int CONV_W = afe_pin_pkg::BUS_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_n,
  input wire logic output_disable,
  input wire afe_pin_pkg::ctrl_pins_type pins,
  input wire logic [afe_pin_pkg::BUS_W-1:0] bus_in,
  output afe_pin_pkg::bus_drive_type shared_output_bus,
  input wire logic [CONV_W-1:0] conv_data,
  input wire logic conv_valid,
  output logic conv_ready,
  output logic clamp_active,
  output afe_pin_pkg::colour_type colour_sel,
  output logic parallel_mode
);

  afe_pin_pkg::afe_state_type q;
  afe_pin_pkg::afe_state_type d;

  logic buf_valid;
  logic buf_pop;
  logic [CONV_W-1:0] buf_data;

  // Back-pressure: a host that stops pulsing sample sync fills the buffer
  pair_buffer #(
    .WIDTH(CONV_W)
  ) u_pair_buffer (
    .clk(clk),
    .srst(srst),
    .in_data(conv_data),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_pop)
  );

  function automatic logic [afe_pin_pkg::BUS_W-1:0] top_piece(
    input logic [afe_pin_pkg::BUS_W-1:0] w,
    input afe_pin_pkg::fmt_type f
  );
    logic [afe_pin_pkg::BUS_W-1:0] r;
    r = w;
    unique case (f)
      afe_pin_pkg::FMT_14: r = w;
      afe_pin_pkg::FMT_8: r = w & ~({afe_pin_pkg::BUS_W{1'b1}} >> afe_pin_pkg::PIECE_W_8);
      afe_pin_pkg::FMT_7: r = w & ~({afe_pin_pkg::BUS_W{1'b1}} >> afe_pin_pkg::PIECE_W_7);
      afe_pin_pkg::FMT_4: r = w & ~({afe_pin_pkg::BUS_W{1'b1}} >> afe_pin_pkg::PIECE_W_4);
    endcase
    return r;
  endfunction

  function automatic logic [afe_pin_pkg::BUS_W-1:0] rest_word(
    input logic [afe_pin_pkg::BUS_W-1:0] w,
    input afe_pin_pkg::fmt_type f
  );
    logic [afe_pin_pkg::BUS_W-1:0] r;
    r = w;
    unique case (f)
      afe_pin_pkg::FMT_14: r = '0;
      afe_pin_pkg::FMT_8: r = w << afe_pin_pkg::PIECE_W_8;
      afe_pin_pkg::FMT_7: r = w << afe_pin_pkg::PIECE_W_7;
      afe_pin_pkg::FMT_4: r = w << afe_pin_pkg::PIECE_W_4;
    endcase
    return r;
  endfunction

  function automatic logic [2:0] piece_count(input afe_pin_pkg::fmt_type f);
    logic [2:0] n;
    n = afe_pin_pkg::PIECES_14;
    unique case (f)
      afe_pin_pkg::FMT_14: n = afe_pin_pkg::PIECES_14;
      afe_pin_pkg::FMT_8: n = afe_pin_pkg::PIECES_8;
      afe_pin_pkg::FMT_7: n = afe_pin_pkg::PIECES_7;
      afe_pin_pkg::FMT_4: n = afe_pin_pkg::PIECES_4;
    endcase
    return n;
  endfunction

  logic [afe_pin_pkg::BYTE_W-1:0] setup;
  afe_pin_pkg::fmt_type fmt;
  logic line_mode;
  logic in_reset;
  logic reset_rise;
  logic strobe_fall;
  logic sck_rise;
  logic enable_rise;
  logic autocycle_rise;
  logic [afe_pin_pkg::BYTE_W-1:0] read_byte;
  logic [afe_pin_pkg::ADDR_W-1:0] ser_addr;

  always_comb begin
    d = q;
    setup = q.regs[afe_pin_pkg::REG_SETUP];
    fmt = afe_pin_pkg::fmt_type'(setup[afe_pin_pkg::FMT_LSB +: 2]);
    line_mode = setup[afe_pin_pkg::LINE_MODE_BIT];
    in_reset = ~reset_n;
    reset_rise = reset_n & ~q.reset_n_prev;
    strobe_fall = ~pins.enable_strobe & q.strobe_prev;
    sck_rise = pins.clock_rw & ~q.sck_prev;
    enable_rise = pins.enable_strobe & ~q.enable_prev;
    autocycle_rise = pins.clamp_autocycle & ~q.autocycle_prev;
    read_byte = q.regs[q.addr];
    ser_addr = q.shift_in[afe_pin_pkg::SER_ADDR_LSB +: afe_pin_pkg::ADDR_W];
    buf_pop = 1'b0;

    d.reset_n_prev = reset_n;
    d.strobe_prev = pins.enable_strobe;
    d.sck_prev = pins.clock_rw;
    d.enable_prev = pins.enable_strobe;
    d.autocycle_prev = pins.clamp_autocycle;

    if (reset_rise) begin
      d.parallel_mode = pins.enable_strobe;
    end

    if (q.parallel_mode) begin
      if (strobe_fall && !pins.clock_rw) begin
        if (pins.data_addr) begin
          d.regs[q.addr] = bus_in[afe_pin_pkg::BUS_W-1 -: afe_pin_pkg::BYTE_W];
        end else begin
          d.addr = bus_in[afe_pin_pkg::UPPER_LSB +: afe_pin_pkg::ADDR_W];
        end
      end
    end else begin
      if (sck_rise) begin
        d.shift_in = {q.shift_in[afe_pin_pkg::SER_FRAME_W-2:0], pins.data_addr};
        if (q.rb_active) begin
          d.rb_shift = {q.rb_shift[afe_pin_pkg::BYTE_W-2:0], 1'b0};
          d.rb_count = q.rb_count - 4'h1;
          d.rb_active = (q.rb_count != 4'h1);
        end
      end
      // Enable pulse closes a frame: address byte then data byte
      if (enable_rise) begin
        d.addr = ser_addr;
        if (q.shift_in[afe_pin_pkg::SER_READ_BIT]) begin
          d.rb_active = 1'b1;
          d.rb_shift = q.regs[ser_addr];
          d.rb_count = afe_pin_pkg::RB_BITS;
        end else begin
          d.regs[ser_addr] = q.shift_in[afe_pin_pkg::BYTE_W-1:0];
        end
      end
    end

    if (pins.video_sample_sync) begin
      if (q.pieces_left > 3'h1) begin
        d.piece = top_piece(q.word, fmt);
        d.word = rest_word(q.word, fmt);
        d.pieces_left = q.pieces_left - 3'h1;
      end else if (buf_valid) begin
        buf_pop = 1'b1;
        d.piece = top_piece(buf_data, fmt);
        d.word = rest_word(buf_data, fmt);
        d.pieces_left = piece_count(fmt);
      end else begin
        d.pieces_left = 3'h0;
      end
      d.clamp_active = pins.clamp_autocycle & ~line_mode;
    end

    if (line_mode && autocycle_rise) begin
      unique case (q.colour_sel)
        afe_pin_pkg::CH_RED: d.colour_sel = afe_pin_pkg::CH_GREEN;
        afe_pin_pkg::CH_GREEN: d.colour_sel = afe_pin_pkg::CH_BLUE;
        default: d.colour_sel = afe_pin_pkg::CH_RED;
      endcase
    end

    if (in_reset) begin
      for (int i = 0; i < afe_pin_pkg::REG_COUNT; i++) begin
        d.regs[i] = afe_pin_pkg::REG_DEFAULT;
      end
      d.addr = '0;
      d.shift_in = '0;
      d.rb_shift = '0;
      d.word = '0;
      d.piece = '0;
      d.rb_active = 1'b0;
      d.rb_count = 4'h0;
      d.pieces_left = 3'h0;
      d.clamp_active = 1'b0;
      d.colour_sel = afe_pin_pkg::CH_RED;
    end

    d.bus.data = d.piece;
    d.bus.oe = '1;
    // Pins follow the mode in force now; a newly latched mode takes over a cycle later
    if (q.parallel_mode) begin
      if (pins.clock_rw) begin
        if (!pins.enable_strobe) begin
          d.bus.data[afe_pin_pkg::BUS_W-1 -: afe_pin_pkg::BYTE_W] = read_byte;
        end
      end else begin
        d.bus.oe[afe_pin_pkg::BUS_W-1 -: afe_pin_pkg::BYTE_W] = '0;
      end
    end else if (d.rb_active) begin
      // Read-back borrows the top bit; pixel data keeps the others
      d.bus.data[afe_pin_pkg::BUS_W-1] = d.rb_shift[afe_pin_pkg::BYTE_W-1];
    end
    if (output_disable) begin
      d.bus.oe = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign shared_output_bus = q.bus;
  assign clamp_active = q.clamp_active;
  assign colour_sel = q.colour_sel;
  assign parallel_mode = q.parallel_mode;

endmodule

// [src/afe_pin_pkg.sv]
package afe_pin_pkg;

  localparam int BUS_W = 14;
  localparam int BYTE_W = 8;
  localparam int UPPER_LSB = 6;
  localparam int REG_COUNT = 8;
  localparam int ADDR_W = 3;

  localparam logic [ADDR_W-1:0] REG_SETUP = 3'h0;
  localparam int FMT_LSB = 0;
  localparam int LINE_MODE_BIT = 2;
  localparam logic [BYTE_W-1:0] REG_DEFAULT = 8'h00;

  localparam int SER_FRAME_W = 16;
  localparam int SER_READ_BIT = 15;
  localparam int SER_ADDR_LSB = 8;
  localparam logic [3:0] RB_BITS = 4'h8;

  localparam logic [2:0] PIECES_14 = 3'h1;
  localparam logic [2:0] PIECES_8 = 3'h2;
  localparam logic [2:0] PIECES_7 = 3'h2;
  localparam logic [2:0] PIECES_4 = 3'h4;

  localparam int PIECE_W_8 = 8;
  localparam int PIECE_W_7 = 7;
  localparam int PIECE_W_4 = 4;

  typedef enum logic [1:0] {FMT_14, FMT_8, FMT_7, FMT_4} fmt_type;
  typedef enum logic [1:0] {CH_RED, CH_GREEN, CH_BLUE} colour_type;

  typedef struct packed {
    logic enable_strobe;
    logic data_addr;
    logic clock_rw;
    logic video_sample_sync;
    logic clamp_autocycle;
  } ctrl_pins_type;

  typedef struct packed {
    logic [BUS_W-1:0] data;
    logic [BUS_W-1:0] oe;
  } bus_drive_type;

  typedef struct packed {
    logic reset_n_prev;
    logic parallel_mode;
    logic [REG_COUNT-1:0][BYTE_W-1:0] regs;
    logic [ADDR_W-1:0] addr;
    logic strobe_prev;
    logic sck_prev;
    logic enable_prev;
    logic autocycle_prev;
    logic [SER_FRAME_W-1:0] shift_in;
    logic rb_active;
    logic [BYTE_W-1:0] rb_shift;
    logic [3:0] rb_count;
    logic [BUS_W-1:0] word;
    logic [2:0] pieces_left;
    logic [BUS_W-1:0] piece;
    bus_drive_type bus;
    logic clamp_active;
    colour_type colour_sel;
  } afe_state_type;

endpackage

// [src/pair_buffer.sv]
`timescale 1ns/1ns
// Two-entry buffer; ready is registered so the source sees no combinational path.
module pair_buffer #(
  parameter int WIDTH = 14
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic ready;
  } pair_state_type;

  pair_state_type q;
  pair_state_type d;
  logic push;
  logic pop;

  always_comb begin
    d = q;
    push = in_valid & q.ready;
    pop = out_ready & (q.count != 2'h0);
    if (push) begin
      d.mem[q.wr_ptr] = in_data;
      d.wr_ptr = ~q.wr_ptr;
    end
    if (pop) begin
      d.rd_ptr = ~q.rd_ptr;
    end
    if (push && !pop) begin
      d.count = q.count + 2'h1;
    end else if (pop && !push) begin
      d.count = q.count - 2'h1;
    end
    d.ready = (d.count != 2'h2);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.ready;
  assign out_valid = (q.count != 2'h0);
  assign out_data = q.mem[q.rd_ptr];

endmodule

// [verif/afe_pin_checker.sv]
`timescale 1ns/1ns
module afe_pin_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_n,
  input wire logic output_disable,
  input wire afe_pin_pkg::ctrl_pins_type pins,
  input wire afe_pin_pkg::bus_drive_type shared_output_bus,
  input wire afe_pin_pkg::colour_type colour_sel,
  input wire logic clamp_active,
  input wire logic parallel_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic rd;
  assign rd = parallel_mode && pins.clock_rw && !pins.enable_strobe;
  chk_oe_disable: assert property (output_disable |=> shared_output_bus.oe == 14'h0)
    else $error("bus driven while disabled");
  chk_mode_latch: assert property ($rose(reset_n) |=> parallel_mode == $past(pins.enable_strobe))
    else $error("mode not latched");
  chk_mode_hold: assert property (!$rose(reset_n) |=> $stable(parallel_mode))
    else $error("mode moved");
  chk_upper_float: assert property (parallel_mode && !pins.clock_rw |=> shared_output_bus.oe[13:6] == 8'h0)
    else $error("upper byte driven in write");
  chk_read_drive: assert property (rd && !output_disable |=> shared_output_bus.oe[13:6] == 8'hff)
    else $error("read byte not driven");
  chk_read_stable: assert property ((rd && !output_disable) [*2] |=> $stable(shared_output_bus.data[13:6]))
    else $error("read byte moved");
  chk_reset_clear: assert property (!reset_n |=> !clamp_active && colour_sel == afe_pin_pkg::CH_RED)
    else $error("state not cleared");
  chk_colour_legal: assert property (colour_sel != 2'h3)
    else $error("bad colour");
  cover property ($rose(reset_n) && pins.enable_strobe);
  cover property (rd && !output_disable);
  cover property (output_disable && shared_output_bus.oe == 14'h0);
endmodule

// [verif/scanner_model.sv]
`timescale 1ns/1ns
module scanner_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  input wire logic conv_ready,
  output logic conv_valid,
  output logic [13:0] conv_data,
  input wire afe_pin_pkg::bus_drive_type dev,
  input wire logic [13:0] host_bits,
  input wire logic host_en,
  output logic [13:0] bus_in
);
  logic tog;
  // Valid is held until taken, so a source that loses interest still hands its word over
  always_ff @(posedge clk) begin
    if (srst) begin
      conv_valid <= 1'b0;
      conv_data <= 14'h1000;
      tog <= 1'b0;
    end else begin
      if (conv_valid && conv_ready) conv_data <= conv_data + 14'h1;
      conv_valid <= go || (conv_valid && !conv_ready);
      tog <= !tog;
    end
  end
  // Released bits toggle so a stale level never passes for data
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      bus_in[i] = dev.oe[i] ? dev.data[i] : host_en ? host_bits[i] : tog ^ i[0];
    end
  end
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic clk = 0, srst = 1, reset_n = 0, output_disable = 0, go = 0, host_en = 0;
  afe_pin_pkg::ctrl_pins_type pins = '0;
  afe_pin_pkg::bus_drive_type bus;
  afe_pin_pkg::colour_type colour_sel;
  logic [13:0] bus_in, conv_data, host_bits = 14'h0, w = 14'h1000;
  logic conv_valid, conv_ready, clamp_active, parallel_mode;
  int fails = 0, cmp_count = 0, cyc = 0;
  always #5 clk = !clk;
  afe_host_pin_interface DUT (.clk, .srst, .reset_n, .output_disable, .pins, .bus_in, .shared_output_bus(bus),
    .conv_data, .conv_valid, .conv_ready, .clamp_active, .colour_sel, .parallel_mode);
  scanner_model host (.clk, .srst, .go, .conv_ready, .conv_valid, .conv_data, .dev(bus), .host_bits, .host_en,
    .bus_in);
  task automatic conclude;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude;
    end
  end
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic boot(logic par);
    reset_n <= 0;
    pins <= {par, 4'h0};
    step(3);
    reset_n <= 1;
    step(2);
    chk(parallel_mode, par);
    chk(clamp_active, 0);
  endtask
  task automatic pwr(logic sel, logic [7:0] v);
    pins.data_addr <= sel;
    pins.clock_rw <= 0;
    host_bits <= {v, 6'h0};
    host_en <= 1;
    step(1);
    pins.enable_strobe <= 0;
    step(1);
    pins.enable_strobe <= 1;
    step(1);
  endtask
  task automatic prd(logic [7:0] e);
    host_en <= 0;
    pins.clock_rw <= 1;
    pins.enable_strobe <= 0;
    step(2);
    chk(bus.data[13:6], e);
    chk(bus.oe[13:6], 8'hff);
    output_disable <= 1;
    step(2);
    chk(bus.oe, 0);
    output_disable <= 0;
    pins.enable_strobe <= 1;
    pins.clock_rw <= 0;
    step(2);
    chk(bus.oe[13:6], 0);
  endtask
  task automatic ser(logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      pins.data_addr <= v[i];
      pins.clock_rw <= 0;
      step(1);
      pins.clock_rw <= 1;
      step(1);
    end
    pins.clock_rw <= 0;
    pins.enable_strobe <= 1;
    step(1);
    pins.enable_strobe <= 0;
    step(2);
  endtask
  task automatic srd(logic [2:0] a, logic [7:0] e);
    ser({5'h10, a, 8'h0});
    for (int i = 7; i >= 0; i--) begin
      chk(bus.data[13], e[i]);
      chk(bus.oe[13], 1);
      pins.clock_rw <= 1;
      step(2);
      pins.clock_rw <= 0;
      step(1);
    end
  endtask
  task automatic pix(int f);
    int wd;
    logic [13:0] e;
    wd = (f == 0) ? 14 : (f == 1) ? 8 : (f == 2) ? 7 : 4;
    ser({8'h00, 8'(f)});
    go <= 1;
    step(1);
    go <= 0;
    step(3);
    for (int k = 0; k < (13 + wd) / wd; k++) begin
      pins.video_sample_sync <= 1;
      step(1);
      pins.video_sample_sync <= 0;
      e = (w << (k * wd)) & ~(14'h3fff >> wd);
      chk(bus.data, e);
      step(1);
    end
    w = w + 1;
  endtask
  task automatic t_par;
    boot(1);
    prd(8'h00);
    pwr(0, 8'h03);
    pwr(1, 8'ha5);
    pwr(0, 8'h05);
    pwr(1, 8'h5a);
    pwr(0, 8'h03);
    prd(8'ha5);
    pwr(0, 8'h05);
    prd(8'h5a);
    boot(1);
    pwr(0, 8'h03);
    prd(8'h00);
  endtask
  task automatic t_line;
    for (int c = 0; c < 2; c++) begin
      pins.clamp_autocycle <= c[0];
      pins.video_sample_sync <= 1;
      step(1);
      pins.video_sample_sync <= 0;
      step(1);
      chk(clamp_active, c[0]);
    end
    pins.clamp_autocycle <= 0;
    ser(16'h0004);
    for (int c = 1; c < 4; c++) begin
      pins.clamp_autocycle <= 1;
      step(1);
      pins.clamp_autocycle <= 0;
      step(2);
      chk(colour_sel, c % 3);
    end
  endtask
  // Receiver stalls until the source is refused, then drains in order
  task automatic t_fill;
    ser(16'h0000);
    go <= 1;
    step(8);
    chk(conv_ready, 0);
    go <= 0;
    for (int n = 0; n < 8 && (w != conv_data || conv_valid); n++) begin
      pins.video_sample_sync <= 1;
      step(1);
      pins.video_sample_sync <= 0;
      chk(bus.data, w);
      w = w + 1;
      step(1);
    end
    chk(conv_ready, 1);
  endtask
  initial begin
    step(8);
    srst <= 0;
    t_par;
    $display("parallel control done");
    boot(0);
    srd(0, 8'h00);
    ser(16'h013c);
    srd(1, 8'h3c);
    $display("serial control done");
    for (int f = 0; f < 4; f++) pix(f);
    $display("formats done");
    t_line;
    $display("clamp and colour done");
    t_fill;
    $display("buffer done");
    conclude;
  end
endmodule
bind afe_host_pin_interface afe_pin_checker chk_i (.clk, .srst, .reset_n, .output_disable, .pins,
  .shared_output_bus, .colour_sel, .clamp_active, .parallel_mode);
